// file: hdl/prs_pkg.sv
package prs_pkg;

    // widths of the counter, stack and bus
    localparam int ADDR_W  = 21;
    localparam int PTR_W   = 5;
    localparam int DEPTH   = 31;
    localparam int BYTE_W  = 8;
    localparam int UPPER_W = 5;

    // register byte offsets on the bus
    localparam logic [7:0] OFS_COUNTER_LOW = 8'h00;
    localparam logic [7:0] OFS_HIGH_LATCH  = 8'h04;
    localparam logic [7:0] OFS_UPPER_LATCH = 8'h08;
    localparam logic [7:0] OFS_STACK_PTR   = 8'h0C;
    localparam logic [7:0] OFS_TOP_LOW     = 8'h10;
    localparam logic [7:0] OFS_TOP_HIGH    = 8'h14;
    localparam logic [7:0] OFS_TOP_UPPER   = 8'h18;
    localparam logic [7:0] OFS_STACK_CMD   = 8'h1C;

    // stack pointer register fields
    localparam int PTR_LSB     = 0;
    localparam int UNDERFLOW_B = 5;
    localparam int OVERFLOW_B  = 6;
    localparam int FULL_B      = 7;

    // stack command register fields (write one to act)
    localparam int CMD_PUSH_B = 0;
    localparam int CMD_POP_B  = 1;

    // reset values and fixed counts
    localparam logic [ADDR_W-1:0] COUNTER_RESET = 21'h000000;
    localparam logic [BYTE_W-1:0] LATCH_RESET   = 8'h00;
    localparam logic [PTR_W-1:0]  PTR_RESET     = 5'h00;
    localparam logic [PTR_W-1:0]  PTR_TOP       = 5'h1F;
    localparam logic [ADDR_W-1:0] WORD_STEP     = 21'h000002;

    // instruction flow operations from the decoder
    typedef enum logic [2:0] {
        PRS_OP_SEQ,
        PRS_OP_CALL,
        PRS_OP_RELATIVE_CALL,
        PRS_OP_JUMP,
        PRS_OP_IRQ_ACK,
        PRS_OP_RET,
        PRS_OP_EXIT_LITERAL,
        PRS_OP_EXIT_INTERRUPT
    } prs_op_e;

    typedef struct packed {
        logic              valid;
        prs_op_e           op;
        logic [ADDR_W-1:0] target;
    } prs_core_op_s;

    typedef struct packed {
        logic full;
        logic overflow;
        logic underflow;
    } prs_status_s;

endpackage

// file: hdl/prs_return_stack.sv
`timescale 1ns/10ps
// What this block does
// RQ1: keeps a 21-bit instruction address counter as low, high and upper bytes.
// RQ2: low byte is software read/write; high byte changes only via its holding latch.
// RQ3: upper byte is not directly accessible; changes only via its holding latch.
// RQ4: writing the low byte also loads high and upper bytes from the latches.
// RQ5: reading the low byte copies high and upper bytes into the latches.
// RQ6: low byte bit zero is always zero, whatever is written.
// RQ7: sequential execution advances the counter by two.
// RQ8: calls, jumps and branches load the counter directly, latches not used.
// RQ9: stack is 31 entries of 21 bits indexed by a 5-bit pointer.
// RQ10: calls and interrupt acknowledge push; the three return kinds pop.
// RQ11: holding latches keep their values across calls and returns.
// RQ12: push increments the pointer first, then writes the return address.
// RQ13: a return pop loads the counter from the selected entry, then decrements; a software pop only decrements.
// RQ14: every reset clears the pointer; pointer zero has no entry behind it.
// RQ15: status bits report stack full, overflow and underflow.
// RQ16: software reads and writes the pointer and can push and pop.
// RQ17: only the selected entry is visible, as upper, high and low bytes.
// RQ18: software masks interrupts while touching the stack top or pointer.
// RQ19: stack storage lies outside program and data address space.
// RQ20: overflow and underflow stay set until software clears them or reset.
module prs_return_stack
    import prs_pkg::*;
(
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire prs_core_op_s       core_op,
    output logic      [ADDR_W-1:0]  instruction_address_counter,
    output prs_status_s             stack_status
);

    // storage lives only here, never mapped into program or data space
    logic [ADDR_W-1:0] stack_mem [1:DEPTH]; // RQ9 RQ19
    logic [PTR_W-1:0]  stack_pointer_reg;
    logic [BYTE_W-1:0] high_holding_latch;
    logic [UPPER_W-1:0] upper_holding_latch;
    logic              overflow_flag;
    logic              underflow_flag;

    logic              acc_done;
    logic              sw_wr;
    logic              sw_rd;
    logic              push_ev;
    logic              pop_ev;
    logic              push_ok;
    logic              pop_ok;
    logic              ovf_set;
    logic              unf_set;
    logic              ptr_wr;
    logic              core_push;
    logic              core_pop;
    logic [ADDR_W-1:0] push_value;
    logic [ADDR_W-1:0] stack_top;
    logic [ADDR_W-1:0] next_counter;
    logic [PTR_W-1:0]  next_ptr;
    logic [31:0]       next_rdata;
    logic              next_err;

    // true when the address is one of the mapped words
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == OFS_COUNTER_LOW) || (a == OFS_HIGH_LATCH)
                 || (a == OFS_UPPER_LATCH) || (a == OFS_STACK_PTR)
                 || (a == OFS_TOP_LOW)     || (a == OFS_TOP_HIGH)
                 || (a == OFS_TOP_UPPER)   || (a == OFS_STACK_CMD);
    endfunction

    // bus access completes on the edge where pready was already high
    assign acc_done = psel && penable && pready;
    // decoder wins a shared edge; a clashing bus side effect is dropped
    assign sw_wr = acc_done && pwrite && !core_op.valid;
    assign sw_rd = acc_done && !pwrite && !core_op.valid;

    assign core_push = core_op.valid && (core_op.op == PRS_OP_CALL
                    || core_op.op == PRS_OP_RELATIVE_CALL
                    || core_op.op == PRS_OP_IRQ_ACK); // RQ10
    assign core_pop = core_op.valid && (core_op.op == PRS_OP_RET
                   || core_op.op == PRS_OP_EXIT_LITERAL
                   || core_op.op == PRS_OP_EXIT_INTERRUPT); // RQ10

    // software push and pop through the command word
    assign push_ev = core_push || (sw_wr && paddr == OFS_STACK_CMD && pwdata[CMD_PUSH_B]); // RQ16
    assign pop_ev  = core_pop || (sw_wr && paddr == OFS_STACK_CMD && pwdata[CMD_POP_B]
                   && !pwdata[CMD_PUSH_B]);
    assign push_ok = push_ev && (stack_pointer_reg != PTR_TOP);
    assign pop_ok  = pop_ev && (stack_pointer_reg != PTR_RESET);
    assign ovf_set = push_ev && (stack_pointer_reg == PTR_TOP);
    assign unf_set = pop_ev && (stack_pointer_reg == PTR_RESET);
    assign ptr_wr  = sw_wr && paddr == OFS_STACK_PTR;

    // pointer zero has no entry and reads as zero
    assign stack_top = (stack_pointer_reg == PTR_RESET) ? COUNTER_RESET
                     : stack_mem[stack_pointer_reg]; // RQ14 RQ17

    // calls save the following instruction; interrupts save the current one
    always_comb begin
        if (core_op.valid && core_op.op != PRS_OP_IRQ_ACK && core_push) begin
            push_value = instruction_address_counter + WORD_STEP; // RQ12
        end else begin
            push_value = instruction_address_counter;
        end
    end

    // next counter value
    always_comb begin
        next_counter = instruction_address_counter;
        if (core_op.valid) begin
            unique case (core_op.op)
                PRS_OP_SEQ: begin
                    next_counter = instruction_address_counter + WORD_STEP; // RQ7
                end
                PRS_OP_CALL, PRS_OP_RELATIVE_CALL, PRS_OP_JUMP, PRS_OP_IRQ_ACK: begin
                    next_counter = {core_op.target[ADDR_W-1:1], 1'b0}; // RQ8
                end
                PRS_OP_RET, PRS_OP_EXIT_LITERAL, PRS_OP_EXIT_INTERRUPT: begin
                    // a software-rewritten top may be odd; keep the counter aligned
                    next_counter = {stack_top[ADDR_W-1:1], 1'b0}; // RQ13 RQ6
                end
            endcase
        end else if (sw_wr && paddr == OFS_COUNTER_LOW) begin
            next_counter = {upper_holding_latch, high_holding_latch,
                            pwdata[BYTE_W-1:1], 1'b0}; // RQ4 RQ6
        end
    end

    // next pointer: push and pop beat a direct pointer write
    always_comb begin
        next_ptr = stack_pointer_reg;
        if (push_ok) begin
            next_ptr = stack_pointer_reg + 5'h01; // RQ12
        end else if (pop_ok) begin
            next_ptr = stack_pointer_reg - 5'h01; // RQ13
        end else if (ptr_wr) begin
            next_ptr = pwdata[PTR_LSB +: PTR_W]; // RQ16
        end
    end

    // counter register, cleared by every reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            instruction_address_counter <= COUNTER_RESET;
        end else begin
            instruction_address_counter <= next_counter; // RQ1 RQ2 RQ3
        end
    end

    // pointer register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stack_pointer_reg <= PTR_RESET; // RQ14
        end else begin
            stack_pointer_reg <= next_ptr;
        end
    end

    // stack entries: push writes the entry above the old pointer
    generate
        for (genvar i = 1; i <= DEPTH; i++) begin : g_entry
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    stack_mem[i] <= COUNTER_RESET;
                end else if (push_ok && (stack_pointer_reg + 5'h01) == PTR_W'(i)) begin
                    stack_mem[i] <= push_value; // RQ12
                end else if (sw_wr && stack_pointer_reg == PTR_W'(i)) begin
                    // only the selected entry can be rewritten
                    if (paddr == OFS_TOP_LOW) begin
                        stack_mem[i][7:0] <= pwdata[7:0]; // RQ17
                    end else if (paddr == OFS_TOP_HIGH) begin
                        stack_mem[i][15:8] <= pwdata[7:0]; // RQ17
                    end else if (paddr == OFS_TOP_UPPER) begin
                        stack_mem[i][ADDR_W-1:16] <= pwdata[UPPER_W-1:0]; // RQ17
                    end
                end
            end
        end
    endgenerate

    // holding latches: software writes, low byte read copies, calls ignore
    always_ff @(posedge pclk or negedge presetn) begin // RQ11
        if (!presetn) begin
            high_holding_latch  <= LATCH_RESET;
            upper_holding_latch <= UPPER_W'(LATCH_RESET);
        end else if (sw_rd && paddr == OFS_COUNTER_LOW) begin
            high_holding_latch  <= instruction_address_counter[15:8]; // RQ5
            upper_holding_latch <= instruction_address_counter[ADDR_W-1:16]; // RQ5
        end else if (sw_wr && paddr == OFS_HIGH_LATCH) begin
            high_holding_latch <= pwdata[BYTE_W-1:0];
        end else if (sw_wr && paddr == OFS_UPPER_LATCH) begin
            upper_holding_latch <= pwdata[UPPER_W-1:0];
        end
    end

    // sticky flags: a set in the clearing cycle survives
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overflow_flag  <= 1'b0;
            underflow_flag <= 1'b0;
        end else begin
            overflow_flag  <= ovf_set || (overflow_flag
                              && !(ptr_wr && !pwdata[OVERFLOW_B])); // RQ15 RQ20
            underflow_flag <= unf_set || (underflow_flag
                              && !(ptr_wr && !pwdata[UNDERFLOW_B])); // RQ15 RQ20
        end
    end

    // status outputs mirror the flag flops, full from the next pointer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stack_status <= '0;
        end else begin
            stack_status.full      <= (next_ptr == PTR_TOP); // RQ15
            stack_status.overflow  <= ovf_set || (overflow_flag
                                      && !(ptr_wr && !pwdata[OVERFLOW_B]));
            stack_status.underflow <= unf_set || (underflow_flag
                                      && !(ptr_wr && !pwdata[UNDERFLOW_B]));
        end
    end

    // read mux; narrower registers sit in the low bits
    always_comb begin
        next_rdata = 32'h00000000;
        next_err   = !is_mapped(paddr);
        unique case (paddr)
            OFS_COUNTER_LOW: next_rdata[7:0] = instruction_address_counter[7:0]; // RQ2
            OFS_HIGH_LATCH:  next_rdata[7:0] = high_holding_latch;
            OFS_UPPER_LATCH: next_rdata[UPPER_W-1:0] = upper_holding_latch;
            OFS_STACK_PTR: begin
                next_rdata[PTR_LSB +: PTR_W] = stack_pointer_reg; // RQ16
                next_rdata[UNDERFLOW_B]      = underflow_flag;
                next_rdata[OVERFLOW_B]       = overflow_flag;
                next_rdata[FULL_B]           = (stack_pointer_reg == PTR_TOP);
            end
            OFS_TOP_LOW:   next_rdata[7:0] = stack_top[7:0]; // RQ17
            OFS_TOP_HIGH:  next_rdata[7:0] = stack_top[15:8];
            OFS_TOP_UPPER: next_rdata[UPPER_W-1:0] = stack_top[ADDR_W-1:16];
            default:       next_rdata = 32'h00000000;
        endcase
    end

    // one wait state keeps pready and prdata straight from flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (psel && penable && !pready) begin
            pready  <= 1'b1;
            prdata  <= pwrite ? 32'h00000000 : next_rdata;
            pslverr <= next_err;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // checks
    sequence s_push;
        push_ok && core_op.valid;
    endsequence

    sequence s_pop;
        pop_ok && core_op.valid;
    endsequence

    a_word_aligned: assert property (@(posedge pclk) disable iff (!presetn) // RQ6
        instruction_address_counter[0] == 1'b0)
        else $error("counter left word boundary");

    a_seq_step: assert property (@(posedge pclk) disable iff (!presetn) // RQ7
        (core_op.valid && core_op.op == PRS_OP_SEQ) |=>
        instruction_address_counter == $past(instruction_address_counter) + WORD_STEP)
        else $error("sequential step not two");

    a_push_order: assert property (@(posedge pclk) disable iff (!presetn) // RQ12
        s_push |=> (stack_pointer_reg == $past(stack_pointer_reg) + 5'h01)
                   && (stack_top == $past(push_value)))
        else $error("push wrote wrong entry");

    a_pop_order: assert property (@(posedge pclk) disable iff (!presetn) // RQ13
        s_pop |=> (instruction_address_counter == {$past(stack_top[ADDR_W-1:1]), 1'b0})
                  && (stack_pointer_reg == $past(stack_pointer_reg) - 5'h01))
        else $error("pop order broken");

    a_latch_keep: assert property (@(posedge pclk) disable iff (!presetn) // RQ11
        (core_push || core_pop) |=> $stable(high_holding_latch)
                                   && $stable(upper_holding_latch))
        else $error("latch changed on call or return");

    a_low_write: assert property (@(posedge pclk) disable iff (!presetn) // RQ4
        (sw_wr && paddr == OFS_COUNTER_LOW) |=>
        instruction_address_counter[ADDR_W-1:8]
            == {$past(upper_holding_latch), $past(high_holding_latch)})
        else $error("low write did not load latches");

    a_low_read: assert property (@(posedge pclk) disable iff (!presetn) // RQ5
        (sw_rd && paddr == OFS_COUNTER_LOW) |=>
        {upper_holding_latch, high_holding_latch}
            == $past(instruction_address_counter[ADDR_W-1:8]))
        else $error("low read did not copy counter");

    a_jump_direct: assert property (@(posedge pclk) disable iff (!presetn) // RQ8
        (core_op.valid && core_op.op == PRS_OP_JUMP) |=>
        instruction_address_counter == {$past(core_op.target[ADDR_W-1:1]), 1'b0})
        else $error("jump target not loaded");

    a_ovf_sticky: assert property (@(posedge pclk) disable iff (!presetn) // RQ20
        (overflow_flag && !ptr_wr) |=> overflow_flag [*1] ##1 1'b1)
        else $error("overflow dropped without clear");

    a_ovf_detect: assert property (@(posedge pclk) disable iff (!presetn) // RQ15
        (push_ev && stack_pointer_reg == PTR_TOP) |=> overflow_flag
            && stack_status.overflow && stack_pointer_reg == PTR_TOP)
        else $error("overflow not reported");

endmodule // prs_return_stack

// file: bench/prs_core_model.sv
`timescale 1ns/10ps
// stands in for the instruction decoder and the interrupt acknowledge path
module prs_core_model
    import prs_pkg::*;
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              req,
    input  wire prs_op_e           req_op,
    input  wire logic [ADDR_W-1:0] req_target,
    input  wire logic [3:0]        req_stall,
    input  wire logic              irq_masked,
    output prs_core_op_s           core_op,
    output logic                   ack
);
    logic [3:0] wait_cnt;

    // one op per request, a single-cycle pulse after a chosen stall
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_op  <= '0;
            ack      <= 1'b0;
            wait_cnt <= '0;
        end else begin
            ack            <= 1'b0;
            core_op.valid  <= 1'b0;
            // junk target while idle, so the block must qualify it by valid
            core_op.target <= ~core_op.target;
            if (req && !ack && !core_op.valid) begin
                if (wait_cnt < req_stall) begin
                    wait_cnt <= wait_cnt + 4'h1;
                end else if (!(irq_masked && req_op == PRS_OP_IRQ_ACK)) begin
                    core_op  <= '{1'b1, req_op, req_target};
                    ack      <= 1'b1;
                    wait_cnt <= '0;
                end
            end
        end
    end
endmodule // prs_core_model

// file: bench/prs_return_stack_bench.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin fail_count++; $display("unexpected %s expected %h seen %h", nm, e, g); end end
module prs_return_stack_bench
    import prs_pkg::*;
;
    logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]        paddr;
    logic [31:0]       pwdata, prdata, rdq, d;
    logic              rde, req, ack, irq_masked, m_ov, m_un;
    prs_core_op_s      core_op;
    prs_status_s       stack_status;
    prs_op_e           req_op;
    logic [ADDR_W-1:0] counter, req_target, m_pc;
    logic [ADDR_W-1:0] m_stk [32];
    logic [3:0]        req_stall;
    logic [PTR_W-1:0]  m_ptr;
    logic [7:0]        m_hl;
    logic [4:0]        m_ul;
    int                fail_count, samples_checked, cycles;
    prs_op_e           calls [3] = '{PRS_OP_CALL, PRS_OP_RELATIVE_CALL, PRS_OP_IRQ_ACK};

    prs_return_stack prs_return_stack_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .core_op(core_op), .instruction_address_counter(counter),
        .stack_status(stack_status)
    );
    prs_core_model prs_core_model_inst (
        .pclk(pclk), .presetn(presetn), .req(req), .req_op(req_op),
        .req_target(req_target), .req_stall(req_stall), .irq_masked(irq_masked),
        .core_op(core_op), .ack(ack)
    );

    // free-running clock, 10 ns period
    always #5 pclk = ~pclk;

    // watchdog: the whole run needs far fewer cycles than this
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 60000) begin
            fail_count++;
            results();
        end
    end

    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // reference model of the counter, latches and stack
    task automatic ref_push(input logic [ADDR_W-1:0] v);
        if (m_ptr == PTR_TOP) begin
            m_ov = 1'b1;
        end else begin
            m_ptr++;
            m_stk[m_ptr] = v;
        end
    endtask

    task automatic ref_pop();
        if (m_ptr == '0) m_un = 1'b1;
        else m_ptr--;
    endtask

    task automatic ref_op(input prs_op_e op, input logic [ADDR_W-1:0] t);
        case (op)
            PRS_OP_SEQ: m_pc = m_pc + WORD_STEP;
            PRS_OP_JUMP: m_pc = {t[20:1], 1'b0};
            PRS_OP_CALL, PRS_OP_RELATIVE_CALL, PRS_OP_IRQ_ACK: begin
                ref_push((op == PRS_OP_IRQ_ACK) ? m_pc : m_pc + WORD_STEP);
                m_pc = {t[20:1], 1'b0};
            end
            default: begin
                m_pc = (m_ptr == '0) ? '0 : {m_stk[m_ptr][20:1], 1'b0};
                ref_pop();
            end
        endcase
    endtask

    task automatic ref_bus(input logic w, input logic [7:0] a, input logic [31:0] v);
        if (w) begin
            case (a)
                OFS_COUNTER_LOW: m_pc = {m_ul, m_hl, v[7:1], 1'b0};
                OFS_HIGH_LATCH:  m_hl = v[7:0];
                OFS_UPPER_LATCH: m_ul = v[4:0];
                OFS_STACK_PTR: begin
                    m_ptr = v[4:0];
                    m_un  = m_un & v[5];
                    m_ov  = m_ov & v[6];
                end
                OFS_TOP_LOW:   if (m_ptr != '0) m_stk[m_ptr][7:0] = v[7:0];
                OFS_TOP_HIGH:  if (m_ptr != '0) m_stk[m_ptr][15:8] = v[7:0];
                OFS_TOP_UPPER: if (m_ptr != '0) m_stk[m_ptr][20:16] = v[4:0];
                OFS_STACK_CMD: if (v[0]) ref_push(m_pc); else if (v[1]) ref_pop();
                default: ;
            endcase
        end else if (a == OFS_COUNTER_LOW) begin
            m_hl = m_pc[15:8];
            m_ul = m_pc[20:16];
        end
    endtask

    function automatic logic [31:0] exp_rd(input logic [7:0] a);
        logic [ADDR_W-1:0] top;
        top = (m_ptr == '0) ? '0 : m_stk[m_ptr];
        case (a)
            OFS_COUNTER_LOW: return {24'h0, m_pc[7:0]};
            OFS_HIGH_LATCH:  return {24'h0, m_hl};
            OFS_UPPER_LATCH: return {27'h0, m_ul};
            OFS_STACK_PTR:   return {24'h0, m_ptr == PTR_TOP, m_ov, m_un, m_ptr};
            OFS_TOP_LOW:     return {24'h0, top[7:0]};
            OFS_TOP_HIGH:    return {24'h0, top[15:8]};
            OFS_TOP_UPPER:   return {27'h0, top[20:16]};
            default:         return '0;
        endcase
    endfunction

    // apb master: holds the request until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= v;
        @(posedge pclk);
        penable <= 1'b1;
        // no local limit: only the watchdog ends a stuck wait
        do @(posedge pclk); while (pready !== 1'b1);
        rdq = prdata;
        rde = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (rde !== 1'b1) ref_bus(w, a, v);
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        apb(1'b1, a, v);
        `CHK("write error", 1'b0, rde)
    endtask

    task automatic rchk(input logic [7:0] a);
        logic [31:0] e;
        e = exp_rd(a);
        apb(1'b0, a, '0);
        `CHK($sformatf("reg %h", a), e, rdq)
        `CHK("read error", 1'b0, rde)
    endtask

    task automatic check_regs();
        logic [7:0] offs [6] = '{OFS_HIGH_LATCH, OFS_UPPER_LATCH, OFS_STACK_PTR,
                                 OFS_TOP_LOW, OFS_TOP_HIGH, OFS_TOP_UPPER};
        foreach (offs[i]) rchk(offs[i]);
    endtask

    task automatic check_state();
        `CHK("counter", m_pc, counter)
        `CHK("full", m_ptr == PTR_TOP, stack_status.full)
        `CHK("overflow", m_ov, stack_status.overflow)
        `CHK("underflow", m_un, stack_status.underflow)
    endtask

    // one core op through the partner, then its reference effect
    task automatic core(input prs_op_e op, input logic [ADDR_W-1:0] t);
        req        <= 1'b1;
        req_op     <= op;
        req_target <= t;
        req_stall  <= 4'($urandom_range(0, 2));
        do @(posedge pclk); while (ack !== 1'b1);
        req <= 1'b0;
        @(posedge pclk);
        ref_op(op, t);
    endtask

    task automatic reset_dut();
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        m_pc = '0; m_ptr = '0; m_hl = '0; m_ul = '0; m_ov = 1'b0; m_un = 1'b0;
        foreach (m_stk[i]) m_stk[i] = '0;
        @(posedge pclk);
    endtask

    initial begin
        pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = '0; pwdata = '0; req = 1'b0; req_op = PRS_OP_SEQ; req_target = '0;
        req_stall = '0; irq_masked = 1'b0; fail_count = 0; samples_checked = 0; cycles = 0;
        void'($urandom(40087));
        @(posedge pclk);
        reset_dut();
        check_state();
        check_regs();
        rchk(OFS_COUNTER_LOW);
        apb(1'b0, 8'h20, '0);
        `CHK("unmapped error", 1'b1, rde)
        `CHK("unmapped data", 32'h0, rdq)
        $display("test reset values done");
        // mixed random instruction flow
        repeat (300) begin
            core(prs_op_e'($urandom_range(0, 7)), ADDR_W'($urandom));
            check_state();
            if ($urandom_range(0, 15) == 0) check_regs();
        end
        $display("test random flow done");
        // fill past the top, then drain past the bottom
        wr(OFS_STACK_PTR, 32'h0);
        for (int i = 0; i < 32; i++) begin
            core(calls[i % 3], ADDR_W'($urandom));
            check_state();
        end
        check_regs();
        core(PRS_OP_SEQ, '0);
        check_state();
        wr(OFS_STACK_PTR, 32'h7F);
        check_regs();
        for (int i = 0; i < 32; i++) begin
            core(prs_op_e'(5 + i % 3), ADDR_W'($urandom));
            check_state();
        end
        wr(OFS_STACK_PTR, 32'h0);
        check_regs();
        $display("test overflow and underflow done");
        // holding latches against the counter
        d = $urandom;
        wr(OFS_HIGH_LATCH, d);
        wr(OFS_UPPER_LATCH, d >> 8);
        wr(OFS_COUNTER_LOW, (d >> 16) | 32'h1);
        check_state();
        core(PRS_OP_CALL, ADDR_W'($urandom));
        core(PRS_OP_RET, '0);
        check_regs();
        core(PRS_OP_JUMP, ADDR_W'($urandom));
        check_state();
        rchk(OFS_COUNTER_LOW);
        check_regs();
        $display("test holding latches done");
        // software access to the stack top, interrupts held off
        irq_masked <= 1'b1;
        wr(OFS_STACK_PTR, 32'h3);
        core(PRS_OP_CALL, ADDR_W'($urandom));
        check_regs();
        // odd low byte: the return must still land on a word boundary
        d = $urandom | 32'h1;
        wr(OFS_TOP_LOW, d);
        wr(OFS_TOP_HIGH, d >> 8);
        wr(OFS_TOP_UPPER, d >> 16);
        core(PRS_OP_RET, '0);
        check_state();
        wr(OFS_STACK_CMD, 32'h1);
        check_regs();
        wr(OFS_STACK_CMD, 32'h2);
        check_regs();
        wr(OFS_STACK_PTR, 32'($urandom_range(1, 30)));
        check_regs();
        wr(OFS_STACK_PTR, 32'h0);
        wr(OFS_TOP_LOW, 32'hFE);
        check_regs();
        irq_masked <= 1'b0;
        $display("test stack top access done");
        // reset in mid-run
        repeat (3) core(PRS_OP_IRQ_ACK, ADDR_W'($urandom));
        reset_dut();
        check_state();
        check_regs();
        $display("test second reset done");
        results();
    end
endmodule // prs_return_stack_bench
